// [rtl/lssc_pkg.sv]
// lssc_pkg.sv: constants and carrier types of the link slot and statistics request handler
package lssc_pkg;

  // message buffer: 18 bytes used, held in five little-endian words
  localparam int MSG_WORDS = 5;
  localparam int MSG_BITS  = 32 * MSG_WORDS;

  // request codes
  localparam logic [7:0] CODE_ADDR = 8'h09;
  localparam logic [7:0] CODE_RECV = 8'h0A;
  localparam logic [7:0] CODE_STAT = 8'h0B;

  // return codes
  localparam logic [7:0] RET_OK      = 8'h00;
  localparam logic [7:0] RET_NOSLOT  = 8'hD1;
  localparam logic [7:0] RET_EMPTY   = 8'hD2;
  localparam logic [7:0] RET_BADADDR = 8'hD3;
  localparam logic [7:0] RET_NOTCTL  = 8'hA1;
  localparam logic [7:0] RET_BADCODE = 8'hFF;

  // request and reply mask bits
  localparam int MASK_WR   = 0;
  localparam int MASK_RD   = 1;
  localparam int MASK_EN   = 2;
  localparam int RPL_VALID = 3;
  localparam int RPL_EN    = 2;

  // fixed slot numbers
  localparam logic [7:0] SLOT_PHYS  = 8'hFD;
  localparam logic [7:0] SLOT_BCAST = 8'hFF;

  // message byte offsets
  localparam int OFS_RSVD = 0;
  localparam int OFS_UID  = 2;
  localparam int OFS_CODE = 6;
  localparam int OFS_RET  = 7;
  localparam int OFS_MASK = 8;
  localparam int OFS_SLOT = 9;
  localparam int OFS_ADDR = 10;
  localparam int OFS_CNT  = 10;
  localparam int OFS_IDX  = 12;
  localparam int OFS_BUF  = 14;

  // bus map, byte addresses within the slave
  localparam logic [11:0] ADDR_REQ  = 12'h000;
  localparam logic [11:0] ADDR_RPL  = 12'h020;
  localparam logic [11:0] ADDR_CTRL = 12'h040;
  localparam logic [11:0] ADDR_STAT = 12'h044;
  localparam logic [11:0] ADDR_COPY = 12'h080;

  // control and status bits
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_ACK   = 2;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_MODE  = 2;
  localparam logic CTRL_MODE_RST = 1'b0;

  // one update of the slot table
  typedef struct packed {
    logic        wr_addr;
    logic [47:0] addr;
    logic        wr_rx;
    logic        rx_val;
  } lssc_slot_op_t;

endpackage

// [rtl/lssc_slot_table.sv]
// lssc_slot_table.sv: address slots with valid and receive-enable state
`timescale 1ns/1ps
`default_nettype none
module lssc_slot_table #(
  parameter  int NMC = 8,
  localparam int SW  = $clog2(NMC + 2)
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // access
  input  wire logic [SW-1:0]         idx,
  input  wire lssc_pkg::lssc_slot_op_t op,
  output logic                       valid,
  output logic                       en,
  output logic [47:0]                addr,
  // receive filter state
  output logic [NMC+1:0]             rx_enable
);
  // index 0 physical, 1..NMC multicast, NMC+1 broadcast
  logic [47:0]    addr_q [NMC+2];
  logic [NMC+1:0] valid_q;
  logic [NMC+1:0] en_q;

  // broadcast slot always reads as valid
  assign valid     = (idx == SW'(NMC + 1)) ? 1'b1 : valid_q[idx];
  assign en        = en_q[idx];
  assign addr      = addr_q[idx];
  assign rx_enable = en_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= '0;
      en_q    <= '0;
    end else begin
      if (op.wr_addr) begin
        valid_q[idx] <= 1'b1;
        en_q[idx]    <= 1'b0; // R20
      end
      if (op.wr_rx) begin
        en_q[idx] <= op.rx_val; // R11
      end
    end
  end

  // address contents are data, not control: no reset
  always_ff @(posedge clk) begin
    if (op.wr_addr) begin
      addr_q[idx] <= op.addr;
    end
  end
endmodule
`default_nettype wire

// [rtl/lssc_stat_ctrs.sv]
// lssc_stat_ctrs.sv: statistics counter array with read and clear ports
`timescale 1ns/1ps
`default_nettype none
module lssc_stat_ctrs #(
  parameter  int N  = 16,
  parameter  int CW = 32,
  localparam int IW = $clog2(N)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // count events
  input  wire logic [N-1:0]  evt,
  // read and clear
  input  wire logic [IW-1:0] rd_idx,
  output logic [CW-1:0]      rd_data,
  input  wire logic          clr,
  input  wire logic [IW-1:0] clr_idx
);
  logic [CW-1:0] cnt_q [N];

  assign rd_data = cnt_q[rd_idx];

  // an event in the clearing cycle is kept: the counter restarts at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (clr && clr_idx == IW'(i)) begin
          cnt_q[i] <= CW'(evt[i]); // R15
        end else if (evt[i]) begin
          cnt_q[i] <= cnt_q[i] + CW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/lssc_cmd_handler.sv]
// lssc_cmd_handler.sv: slot, receive-control and statistics request handler
//
// Contract
// [R1] user id copied unchanged into the reply
// [R2] codes 09h, 0Ah, 0Bh select; code echoed
// [R3] slot requests: zero, or D1h bad slot
// [R4] wrong address kind or slot 255: D3h
// [R5] not in controller mode: A1h
// [R6] mask 01 write, 02 read, both allowed
// [R7] address read: reply bit 3 shows prior valid
// [R8] address slots: 253 or multicast 1..limit
// [R9] read returns prior address of occupied slot
// [R10] receive control on empty slot: D2h
// [R11] write sets receive enable from bit 04
// [R12] read: reply bit 2 shows prior enable
// [R13] receive control accepts 253, 255, multicast
// [R14] statistics read copies counters, reply last
// [R15] statistics write clears requested counters
// [R16] start index beyond array: nothing touched
// [R17] read and write: copy before clear
// [R18] reserved field ignored, zero in reply
// [R19] count at 10, index 12, buffer 14
// [R20] address write disables slot receive
// [R21] count truncated; reply gives processed count
// [R22] reply written after all side effects
// [R23] undefined reply fields driven zero
`timescale 1ns/1ps
`default_nettype none
module lssc_cmd_handler #(
  parameter  int NMC   = 8,
  parameter  int NSTAT = 16,
  parameter  int CW    = 32,
  localparam int SW    = $clog2(NMC + 2),
  localparam int IW    = $clog2(NSTAT)
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // statistics events, same clock
  input  wire logic [NSTAT-1:0] stat_evt,
  // status toward the receive path
  output logic [NMC+1:0]        rx_enable,
  output logic                  busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_COPY, ST_CLEAR, ST_REPLY} lssc_state_t;

  localparam int MB = lssc_pkg::MSG_BITS;

  lssc_state_t st_q;
  lssc_state_t st_d;
  logic [MB-1:0] req_q;
  logic [MB-1:0] msg_q;
  logic [MB-1:0] rpl_q;
  logic [MB-1:0] rpl_d;
  logic [11:0]   a_q;
  logic          wpend_q;
  logic          rpend_q;
  logic          mode_q;
  logic          done_q;
  logic [7:0]    ret_q;
  logic [7:0]    rmask_q;
  logic [47:0]   raddr_q;
  logic [15:0]   act_q;
  logic [15:0]   k_q;
  logic [31:0]   copy_q [NSTAT];
  lssc_pkg::lssc_slot_op_t sop;
  logic          sl_valid;
  logic          sl_en;
  logic [47:0]   sl_addr;
  logic [CW-1:0] ctr_rd;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes commit in the data phase, reads take one wait

  wire        acc     = hsel && htrans[1] && hready;
  wire [2:0]  a_w     = a_q[4:2];
  wire        in_req  = a_q[11:5] == lssc_pkg::ADDR_REQ[11:5] && a_w < 3'(lssc_pkg::MSG_WORDS);
  wire        in_rpl  = a_q[11:5] == lssc_pkg::ADDR_RPL[11:5] && a_w < 3'(lssc_pkg::MSG_WORDS);
  wire        is_ctrl = a_q == lssc_pkg::ADDR_CTRL;
  wire        is_stat = a_q == lssc_pkg::ADDR_STAT;
  wire        in_copy = a_q[11:7] == lssc_pkg::ADDR_COPY[11:7] && 32'(a_q[6:2]) < NSTAT;
  wire [31:0] stat_w  = 32'({mode_q, done_q, busy});
  wire [31:0] ctrl_w  = 32'({mode_q, 1'b0});
  wire [31:0] rd_mux  = in_req  ? req_q[32*a_w +: 32] :
                        in_rpl  ? rpl_q[32*a_w +: 32] :
                        is_ctrl ? ctrl_w :
                        is_stat ? stat_w :
                        in_copy ? copy_q[IW'(a_q[6:2])] : 32'h0000_0000;
  // request words are frozen while a request runs
  wire        wr_req  = wpend_q && in_req && !busy;
  wire        wr_ctrl = wpend_q && is_ctrl;
  wire        start_w = wr_ctrl && hwdata[lssc_pkg::CTRL_START] && st_q == ST_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_q   <= 1'b0;
      rpend_q   <= 1'b0;
      a_q       <= 12'h000;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      wpend_q   <= acc && hwrite;
      rpend_q   <= acc && !hwrite;
      hreadyout <= !(acc && !hwrite);
      hresp     <= 1'b0;
      if (acc) begin
        a_q <= haddr[11:0];
      end
      if (rpend_q) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q  <= '0;
      mode_q <= lssc_pkg::CTRL_MODE_RST;
    end else begin
      if (wr_req) begin
        req_q[32*a_w +: 32] <= hwdata;
      end
      if (wr_ctrl) begin
        mode_q <= hwdata[lssc_pkg::CTRL_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request fields

  wire [31:0] c_uid   = msg_q[8*lssc_pkg::OFS_UID +: 32];
  wire [7:0]  c_code  = msg_q[8*lssc_pkg::OFS_CODE +: 8];
  wire [7:0]  c_mask  = msg_q[8*lssc_pkg::OFS_MASK +: 8];
  wire [7:0]  c_slot  = msg_q[8*lssc_pkg::OFS_SLOT +: 8];
  wire [47:0] c_naddr = msg_q[8*lssc_pkg::OFS_ADDR +: 48];
  wire [15:0] c_cnt   = msg_q[8*lssc_pkg::OFS_CNT +: 16]; // R19
  wire [15:0] c_idx   = msg_q[8*lssc_pkg::OFS_IDX +: 16]; // R19
  wire        c_wr    = c_mask[lssc_pkg::MASK_WR]; // R6
  wire        c_rd    = c_mask[lssc_pkg::MASK_RD]; // R6
  wire        c_en    = c_mask[lssc_pkg::MASK_EN];
  wire        c_addr  = c_code == lssc_pkg::CODE_ADDR; // R2
  wire        c_recv  = c_code == lssc_pkg::CODE_RECV; // R2
  wire        c_stat  = c_code == lssc_pkg::CODE_STAT; // R2
  wire        c_phys  = c_slot == lssc_pkg::SLOT_PHYS;
  wire        c_bc    = c_slot == lssc_pkg::SLOT_BCAST;
  wire        mc_ok   = c_slot != 8'h00 && c_slot <= 8'(NMC);
  wire        a_slok  = c_phys || mc_ok; // R8
  wire        r_slok  = c_phys || c_bc || mc_ok; // R13
  wire        mc_addr = c_naddr[0];
  wire [SW-1:0] sidx  = c_phys ? '0 : c_bc ? SW'(NMC + 1) : SW'(c_slot);
  wire        in_exec = st_q == ST_EXEC && mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // decisions taken in the execute cycle

  wire [7:0] ret_addr = (c_wr && c_bc) ? lssc_pkg::RET_BADADDR : // R4
                        !a_slok ? lssc_pkg::RET_NOSLOT : // R3
                        (c_wr && c_phys == mc_addr) ? lssc_pkg::RET_BADADDR : // R4
                        lssc_pkg::RET_OK;
  wire [7:0] ret_recv = !r_slok ? lssc_pkg::RET_NOSLOT : // R3
                        !sl_valid ? lssc_pkg::RET_EMPTY : // R10
                        lssc_pkg::RET_OK;
  wire [7:0] ret_d    = !mode_q ? lssc_pkg::RET_NOTCTL : // R5
                        c_addr ? ret_addr :
                        c_recv ? ret_recv :
                        c_stat ? lssc_pkg::RET_OK : lssc_pkg::RET_BADCODE;
  wire       a_seen   = c_addr && c_rd && a_slok;
  wire       r_seen   = c_recv && c_rd && r_slok;
  wire [7:0] rmask_d  = !mode_q ? 8'h00 :
                        a_seen ? 8'(sl_valid) << lssc_pkg::RPL_VALID : // R7
                        r_seen ? 8'(sl_en) << lssc_pkg::RPL_EN : 8'h00; // R12
  wire [47:0] raddr_d = (mode_q && a_seen && sl_valid) ? sl_addr : 48'h0000_0000_0000; // R9

  // clip the count to the end of the array, nothing past it
  wire [16:0] st_rem  = 17'(NSTAT) - {1'b0, c_idx};
  wire        st_oob  = {1'b0, c_idx} >= 17'(NSTAT); // R16
  wire [15:0] st_act  = st_oob ? 16'h0000 :
                        ({1'b0, c_cnt} < st_rem) ? c_cnt : st_rem[15:0]; // R21
  wire        st_work = mode_q && c_stat && st_act != 16'h0000 && (c_rd || c_wr);
  wire        k_last  = k_q == act_q - 16'h0001;
  wire [IW-1:0] ctr_idx = IW'(c_idx + k_q);

  assign sop.wr_addr = in_exec && c_addr && c_wr && ret_addr == lssc_pkg::RET_OK; // R20
  assign sop.addr    = c_naddr;
  assign sop.wr_rx   = in_exec && c_recv && c_wr && ret_recv == lssc_pkg::RET_OK; // R11
  assign sop.rx_val  = c_en;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:  if (start_w) st_d = ST_EXEC;
      ST_EXEC:  st_d = !st_work ? ST_REPLY : c_rd ? ST_COPY : ST_CLEAR;
      ST_COPY:  if (k_last) st_d = c_wr ? ST_CLEAR : ST_REPLY; // R17
      ST_CLEAR: if (k_last) st_d = ST_REPLY;
      ST_REPLY: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      k_q  <= 16'h0000;
    end else begin
      st_q <= st_d;
      k_q  <= (st_d != st_q) ? 16'h0000 : k_q + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_q   <= '0;
      ret_q   <= 8'h00;
      rmask_q <= 8'h00;
      raddr_q <= 48'h0000_0000_0000;
      act_q   <= 16'h0000;
    end else if (start_w) begin
      msg_q <= req_q;
    end else if (st_q == ST_EXEC) begin
      ret_q   <= ret_d;
      rmask_q <= rmask_d;
      raddr_q <= raddr_d;
      act_q   <= (mode_q && c_stat) ? st_act : 16'h0000;
    end
  end

  // copied counters, readable once done is seen
  always_ff @(posedge hclk) begin
    if (st_q == ST_COPY) begin
      copy_q[IW'(k_q)] <= 32'(ctr_rd); // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply assembly: echo what the request gave, zero the rest

  always_comb begin
    rpl_d = msg_q; // R1
    rpl_d[8*lssc_pkg::OFS_RSVD +: 16] = 16'h0000; // R18
    rpl_d[8*lssc_pkg::OFS_RET +: 8]   = ret_q;
    rpl_d[8*lssc_pkg::OFS_MASK +: 8]  = rmask_q;
    if (c_stat) begin
      rpl_d[8*lssc_pkg::OFS_SLOT +: 8] = 8'h00; // R23
      rpl_d[8*lssc_pkg::OFS_CNT +: 16] = act_q; // R21
    end else if (c_addr) begin
      rpl_d[8*lssc_pkg::OFS_ADDR +: 48] = raddr_q;
      rpl_d[MB-1:8*lssc_pkg::OFS_ADDR+48] = '0;
    end else begin
      rpl_d[MB-1:8*lssc_pkg::OFS_ADDR] = '0; // R23
    end
  end

  // done set wins over an acknowledge in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rpl_q  <= '0;
      done_q <= 1'b0;
      busy   <= 1'b0;
    end else begin
      if (st_q == ST_REPLY) begin
        rpl_q  <= rpl_d; // R22
        done_q <= 1'b1;
      end else if (wr_ctrl && hwdata[lssc_pkg::CTRL_ACK]) begin
        done_q <= 1'b0;
      end
      if (start_w) begin
        busy <= 1'b1;
      end else if (st_q == ST_REPLY) begin
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  lssc_slot_table #(.NMC(NMC)) u_slots (
    .clk       (hclk),
    .rst_n     (hresetn),
    .idx       (sidx),
    .op        (sop),
    .valid     (sl_valid),
    .en        (sl_en),
    .addr      (sl_addr),
    .rx_enable (rx_enable)
  );

  lssc_stat_ctrs #(.N(NSTAT), .CW(CW)) u_ctrs (
    .clk     (hclk),
    .rst_n   (hresetn),
    .evt     (stat_evt),
    .rd_idx  (ctr_idx),
    .rd_data (ctr_rd),
    .clr     (st_q == ST_CLEAR), // R15
    .clr_idx (ctr_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_uid_echo: assert property (st_q == ST_REPLY |=> // R1
    rpl_q[8*lssc_pkg::OFS_UID +: 32] == c_uid) else $error("user id not echoed");
  a_code_echo: assert property (st_q == ST_REPLY |=> // R2
    rpl_q[8*lssc_pkg::OFS_CODE +: 8] == c_code) else $error("code not echoed");
  a_mode_fail: assert property (st_q == ST_EXEC && !mode_q |-> ##2 done_q && // R5
    rpl_q[8*lssc_pkg::OFS_RET +: 8] == lssc_pkg::RET_NOTCTL) else $error("mode fail");
  a_slot_bad: assert property (in_exec && c_addr && !c_wr && !a_slok |-> ##2 // R3
    rpl_q[8*lssc_pkg::OFS_RET +: 8] == lssc_pkg::RET_NOSLOT) else $error("bad slot");
  a_bcast_write: assert property (in_exec && c_addr && c_wr && c_bc |-> !sop.wr_addr ##2 // R4
    rpl_q[8*lssc_pkg::OFS_RET +: 8] == lssc_pkg::RET_BADADDR) else $error("slot 255 written");
  a_recv_empty: assert property (in_exec && c_recv && r_slok && !sl_valid |-> ##2 // R10
    rpl_q[8*lssc_pkg::OFS_RET +: 8] == lssc_pkg::RET_EMPTY) else $error("empty slot");
  a_valid_bit: assert property (in_exec && a_seen |-> ##2 // R7
    rpl_q[8*lssc_pkg::OFS_MASK+lssc_pkg::RPL_VALID] == $past(sl_valid, 2))
    else $error("valid bit");
  a_wr_rx_off: assert property (sop.wr_addr |=> !rx_enable[$past(sidx)]) // R20
    else $error("receive left on");
  a_rx_set: assert property (sop.wr_rx |=> rx_enable[$past(sidx)] == $past(c_en)) // R11
    else $error("receive enable");
  a_trunc: assert property (st_q == ST_EXEC |=> 32'(act_q) <= NSTAT) // R21
    else $error("count past array");
  a_oob_none: assert property (st_q == ST_EXEC && c_stat && st_oob |=> // R16
    st_q == ST_REPLY && act_q == 16'h0000) else $error("out of range touched");
  a_copy_first: assert property (st_q == ST_CLEAR && $past(st_q) == ST_EXEC |-> !c_rd) // R17
    else $error("clear before copy");
  a_reply_last: assert property ($rose(done_q) |-> $past(st_q) == ST_REPLY) // R22
    else $error("early reply");

  c_addr_done: cover property (st_q == ST_REPLY && c_addr && ret_q == lssc_pkg::RET_OK);
  c_recv_done: cover property (st_q == ST_REPLY && c_recv && ret_q == lssc_pkg::RET_OK);
  c_stat_both: cover property (st_q == ST_COPY ##[1:64] st_q == ST_CLEAR);
endmodule
`default_nettype wire

// [tb/lssc_host_model.sv]
// lssc_host_model.sv: host-side bus master that issues single word transfers
`timescale 1ns/1ps
`default_nettype none
module lssc_host_model (
  // bus toward the handler
  input  wire logic   hclk,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  input  wire logic   hready,
  // waits that ran out
  output int          timeouts
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    timeouts = 0;
  end

  // a slow slave may stretch any phase, so never assume a count
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 200);
    if (n >= 200) timeouts++;
  endtask

  // caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= w ? d : ~d;
    wait_rdy();
    // stale data would hide a late sample
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// tb_top.sv: self-checking bench for the slot and statistics request handler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [15:0] stat_evt;
  logic [9:0]  rx_enable;
  logic        busy;
  int          tmo;
  int          failures;
  int          n_checks;
  logic [31:0] exp_q[$];
  logic [31:0] ctr[16];
  logic        rd_pend = 1'b0;
  logic        mode_on;

  lssc_cmd_handler i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stat_evt(stat_evt),
    .rx_enable(rx_enable), .busy(busy));
  lssc_host_model i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .timeouts(tmo));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data is taken at the edge closing the read data phase
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      cmp({31'h0, hresp}, 32'h0000_0000);
      if (exp_q.size() == 0) failures++;
      else cmp(hrdata, exp_q.pop_front());
    end
    if (hreadyout === 1'b1) rd_pend = hsel && htrans[1] && !hwrite;
  end

  // a bus wait that ran out ends the run at once
  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(w, a, d);
    if (tmo != 0) conclude();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xf(1'b0, a, 32'h0000_0000);
  endtask

  task automatic run(input logic [31:0] r[5], input logic [31:0] e[5]);
    int n;
    for (int i = 0; i < 5; i++) begin
      xf(1'b1, 32'(4 * i), r[i]);
    end
    xf(1'b1, 32'h0000_0040, {30'h0, mode_on, 1'b1});
    n = 0;
    @(posedge hclk);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) begin
      failures++;
      conclude();
    end
    for (int i = 0; i < 5; i++) begin
      rd(32'h0000_0020 + 32'(4 * i), e[i]);
    end
  endtask

  // reserved request field always zero; undefined reply fields expected zero
  task automatic sreq(input logic [7:0] c, input logic [7:0] m, input logic [7:0] s,
                      input logic [47:0] a, input logic [7:0] rc, input logic [7:0] rm,
                      input logic [47:0] ea);
    logic [31:0] u;
    u = $urandom;
    run('{{u[15:0], 16'h0000}, {8'h00, c, u[31:16]}, {a[15:0], s, m}, a[47:16], 32'h0},
        '{{u[15:0], 16'h0000}, {rc, c, u[31:16]}, {ea[15:0], s, rm}, ea[47:16], 32'h0});
  endtask

  task automatic stat_req(input logic [7:0] m, input logic [15:0] cnt, input logic [15:0] idx);
    logic [31:0] u;
    logic [31:0] b;
    logic [15:0] np;
    u = $urandom;
    b = $urandom;
    np = (idx >= 16) ? 16'h0000 : ((cnt > 16'd16 - idx) ? 16'd16 - idx : cnt);
    run('{{u[15:0], 16'h0000}, {8'h00, 8'h0B, u[31:16]}, {cnt, 8'h00, m}, {b[15:0], idx},
          {16'h0000, b[31:16]}},
        '{{u[15:0], 16'h0000}, {8'h00, 8'h0B, u[31:16]}, {np, 16'h0000}, {b[15:0], idx},
          {16'h0000, b[31:16]}});
    for (int i = 0; i < 16; i++) begin
      if (m[1] && i < np) rd(32'h0000_0080 + 32'(4 * i), ctr[idx + i]);
    end
    for (int i = 0; i < 16; i++) begin
      if (m[0] && i < np) ctr[idx + i] = 32'h0000_0000;
    end
  endtask

  task automatic conclude();
    failures += tmo + exp_q.size();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    logic [15:0] ev;
    logic [47:0] mc;
    hresetn = 1'b0;
    stat_evt = 16'h0000;
    failures = 0;
    n_checks = 0;
    mode_on = 1'b0;
    foreach (ctr[i]) ctr[i] = 32'h0000_0000;
    void'($urandom(46));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (40) begin
      @(posedge hclk);
      ev = 16'($urandom);
      stat_evt <= ev;
      for (int i = 0; i < 16; i++) ctr[i] += 32'(ev[i]);
    end
    @(posedge hclk);
    stat_evt <= 16'h0000;
    @(posedge hclk);
    mc = {$urandom, 16'($urandom)} | 48'h0000_0000_0001;
    sreq(8'h09, 8'h02, 8'h01, mc, 8'hA1, 8'h00, 48'h0);
    mode_on = 1'b1;
    sreq(8'h09, 8'h03, 8'h01, mc, 8'h00, 8'h00, 48'h0);
    sreq(8'h09, 8'h02, 8'h01, 48'h0, 8'h00, 8'h08, mc);
    sreq(8'h09, 8'h01, 8'hFD, mc, 8'hD3, 8'h00, 48'h0);
    sreq(8'h09, 8'h01, 8'h01, mc ^ 48'h1, 8'hD3, 8'h00, 48'h0);
    sreq(8'h09, 8'h01, 8'hFF, mc, 8'hD3, 8'h00, 48'h0);
    sreq(8'h09, 8'h02, 8'h00, 48'h0, 8'hD1, 8'h00, 48'h0);
    sreq(8'h09, 8'h02, 8'h09, 48'h0, 8'hD1, 8'h00, 48'h0);
    sreq(8'h09, 8'h03, 8'hFD, mc ^ 48'h1, 8'h00, 8'h00, 48'h0);
    sreq(8'h09, 8'h02, 8'h01, 48'h0, 8'h00, 8'h08, mc);
    sreq(8'h0A, 8'h05, 8'h01, 48'h0, 8'h00, 8'h00, 48'h0);
    cmp(32'(rx_enable), 32'h0000_0002);
    sreq(8'h0A, 8'h02, 8'h01, 48'h0, 8'h00, 8'h04, 48'h0);
    sreq(8'h09, 8'h01, 8'h01, mc, 8'h00, 8'h00, 48'h0);
    cmp(32'(rx_enable), 32'h0000_0000);
    sreq(8'h0A, 8'h05, 8'h02, 48'h0, 8'hD2, 8'h00, 48'h0);
    sreq(8'h0A, 8'h07, 8'hFF, 48'h0, 8'h00, 8'h00, 48'h0);
    sreq(8'h0A, 8'h05, 8'hFD, 48'h0, 8'h00, 8'h00, 48'h0);
    cmp(32'(rx_enable), 32'h0000_0201);
    sreq(8'h0C, 8'h02, 8'h01, 48'h0, 8'hFF, 8'h00, 48'h0);
    stat_req(8'h03, 16'd5, 16'd14);
    stat_req(8'h03, 16'd3, 16'd16);
    stat_req(8'h01, 16'd2, 16'd0);
    stat_req(8'h02, 16'd16, 16'd0);
    rd(32'h0000_0044, 32'h0000_0006);
    xf(1'b1, 32'h0000_0040, 32'h0000_0006);
    rd(32'h0000_0044, 32'h0000_0004);
    rd(32'h0000_0040, 32'h0000_0002);
    rd(32'h0000_0100, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    conclude();
  end
endmodule
`default_nettype wire
